// ---- core/keypad_ascii_command_queue.sv ----
// keypad scan, ascii translation and command byte queue
// Operation
// - key press raises event; rows scanned to find cross-point address
// - cross-point address translated to ascii by fixed lookup table
// - digit and punctuation keys map to their ascii characters
// - function keys map to letters A-F, S, R, I, K, L
// - each ascii byte stored in 64-entry circular queue, or dropped with a key_dropped_out pulse when 64 bytes are already held
// - separate write and read pointers, both wrapping
// - empty when pointers match; read takes oldest, advances read pointer
`timescale 1ns/1ps
module keypad_ascii_command_queue
  import keypad_queue_pkg::*;
#(
  parameter int DEPTH = QUEUE_DEPTH,
  parameter int WIDTH = CHAR_W
) (
  input  wire logic             clock_in,
  input  wire logic             sys_rst_in,
  input  wire logic [3:0]       row_drive_unused_in,
  input  wire logic [2:0]       col_sense_in,
  output logic      [3:0]       row_drive_out,
  output logic                  key_event_out,
  output logic                  key_dropped_out,
  output logic      [WIDTH-1:0] rd_data_out,
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in,
  output logic                  empty_out,
  output logic                  full_out
);
  // two-flop synchronisers on the column sense and bank select pins
  logic [2:0] col_meta_reg;
  logic [2:0] col_sync_reg;
  logic [3:0] bank_meta_reg;
  logic [3:0] bank_sync_reg;
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      col_meta_reg  <= 3'h0;
      col_sync_reg  <= 3'h0;
      bank_meta_reg <= 4'h0;
      bank_sync_reg <= 4'h0;
    end else begin
      col_meta_reg  <= col_sense_in;
      col_sync_reg  <= col_meta_reg;
      bank_meta_reg <= row_drive_unused_in;
      bank_sync_reg <= bank_meta_reg;
    end
  end

  scan_state_type state_reg;
  scan_state_type state_next;
  logic [1:0]     row_reg;
  logic [1:0]     row_next;
  logic [7:0]     char_reg;
  logic           push_reg;
  logic           event_reg;
  logic           drop_reg;
  logic           stage_ready;
  logic [1:0]     settle_reg;
  logic [1:0]     settle_next;
  localparam int  AW = $clog2(DEPTH);
  localparam logic [AW:0] HELD_MAX = (AW+1)'(DEPTH);
  logic [AW:0]    held_reg;

  wire any_key   = |col_sync_reg;
  wire [1:0] col_idx = col_sync_reg[0] ? 2'd0 : (col_sync_reg[1] ? 2'd1 : 2'd2);
  // keypad wiring: rows C,D,E,F; columns low nibble 1,2,0 / 9,a,b
  wire [3:0] row_hi  = 4'hc + {2'b00, row_reg};
  wire [3:0] col_lo  = (col_idx == 2'd0) ? 4'h1 : ((col_idx == 2'd1) ? 4'h2 : 4'h0);
  wire [7:0] xpoint  = {row_hi, col_lo};
  wire [7:0] xpoint_b = {row_hi, col_lo + 4'h8 + ((col_idx == 2'd2) ? 4'h3 : 4'h0)};
  wire       use_b   = bank_sync_reg[row_reg];
  wire [7:0] xp_sel  = use_b ? xpoint_b : xpoint;
  wire [7:0] char_lk = xpoint_to_char(xp_sel);

  // all rows driven while idle so any press is seen; one row at a time, three cycles each, while scanning
  assign row_drive_out = (state_reg == ST_SCAN) ? (4'h1 << row_reg) : 4'hf;

  always_comb begin
    state_next  = state_reg;
    row_next    = row_reg;
    settle_next = 2'h0;
    unique case (state_reg)
      ST_IDLE: begin
        if (any_key) begin
          state_next = ST_SCAN;
          row_next   = 2'd0;
        end
      end
      ST_SCAN: begin
        if (settle_reg != SCAN_SETTLE) begin
          // columns lag the row drive by two flops, so each row dwells for its own reading
          settle_next = settle_reg + 2'h1;
        end else if (any_key || row_reg == 2'd3) begin
          state_next = ST_WAIT;
        end else begin
          row_next = row_reg + 2'd1;
        end
      end
      ST_WAIT: begin
        if (!any_key) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  wire found     = (state_reg == ST_SCAN) && (settle_reg == SCAN_SETTLE) && any_key && (char_lk != CHAR_NONE);
  // limit counts every unread byte, stage and output register too, so 64 is exact
  wire held_full = (held_reg == HELD_MAX);
  wire accept    = found && !held_full && stage_ready;

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_reg <= ST_IDLE;
      row_reg   <= 2'd0;
      char_reg  <= 8'h00;
      push_reg  <= 1'b0;
      event_reg <= 1'b0;
      drop_reg  <= 1'b0;
      settle_reg <= 2'h0;
    end else begin
      state_reg <= state_next;
      row_reg   <= row_next;
      settle_reg <= settle_next;
      event_reg <= (state_reg == ST_IDLE) && any_key;
      push_reg  <= accept;
      drop_reg  <= found && !accept;
      if (found) begin
        char_reg <= char_lk;
      end
    end
  end

  assign key_event_out   = event_reg;
  assign key_dropped_out = drop_reg;

  // main 64-byte circular queue
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  logic [WIDTH-1:0] out_reg;
  logic             out_valid_reg;
  logic             st_valid;
  logic [WIDTH-1:0] st_data;
  logic             st_ready;

  // small staging fifo decouples scan from the queue write
  keypad_stage_fifo #(.WIDTH(WIDTH), .DEPTH(STAGE_DEPTH)) stage_u (
    .clock_in    (clock_in),
    .sys_rst_in  (sys_rst_in),
    .in_data_in  (char_reg),
    .in_valid_in (push_reg),
    .in_ready_out(stage_ready),
    .out_data_out(st_data),
    .out_valid_out(st_valid),
    .out_ready_in(st_ready)
  );

  wire q_empty = (wr_ptr_reg == rd_ptr_reg);
  wire q_full  = (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]) && (wr_ptr_reg[AW] != rd_ptr_reg[AW]);
  assign st_ready = !q_full;
  wire do_wr   = st_valid && !q_full;
  wire load    = !q_empty && (!out_valid_reg || rd_ready_in);
  wire take    = out_valid_reg && rd_ready_in;
  wire [AW:0] held_next = held_reg + {{AW{1'b0}}, accept} - {{AW{1'b0}}, take};

  always_ff @(posedge clock_in) begin
    if (do_wr) begin
      mem[wr_ptr_reg[AW-1:0]] <= st_data;
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wr_ptr_reg    <= '0;
      rd_ptr_reg    <= '0;
      out_reg       <= '0;
      out_valid_reg <= 1'b0;
      held_reg      <= '0;
    end else begin
      held_reg <= held_next;
      if (do_wr) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (load) begin
        out_reg    <= mem[rd_ptr_reg[AW-1:0]];
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
        out_valid_reg <= 1'b1;
      end else if (rd_ready_in) begin
        out_valid_reg <= 1'b0;
      end
    end
  end

  assign rd_data_out  = out_reg;
  assign rd_valid_out = out_valid_reg;
  assign empty_out    = (held_reg == '0);
  assign full_out     = held_full;
endmodule

// parameterised valid/ready staging fifo
module keypad_stage_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clock_in,
  input  wire logic             sys_rst_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  output logic      [WIDTH-1:0] out_data_out,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] buf_mem [DEPTH];
  logic [AW:0]      wp_reg;
  logic [AW:0]      rp_reg;
  wire empty = (wp_reg == rp_reg);
  wire full  = (wp_reg[AW-1:0] == rp_reg[AW-1:0]) && (wp_reg[AW] != rp_reg[AW]);
  wire wr    = in_valid_in && !full;
  wire rd    = out_ready_in && !empty;
  assign in_ready_out  = !full;
  assign out_valid_out = !empty;
  assign out_data_out  = buf_mem[rp_reg[AW-1:0]];
  always_ff @(posedge clock_in) begin
    if (wr) begin
      buf_mem[wp_reg[AW-1:0]] <= in_data_in;
    end
  end
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wp_reg <= '0;
      rp_reg <= '0;
    end else begin
      if (wr) begin
        wp_reg <= wp_reg + 1'b1;
      end
      if (rd) begin
        rp_reg <= rp_reg + 1'b1;
      end
    end
  end
endmodule

// ---- core/keypad_queue_pkg.sv ----
// constants shared by the keypad command queue
package keypad_queue_pkg;
  localparam int          QUEUE_DEPTH   = 64;
  localparam int          STAGE_DEPTH   = 4;
  localparam int          ADDR_W        = 8;
  localparam int          CHAR_W        = 8;
  localparam logic [7:0]  CHAR_NONE     = 8'h00;
  localparam logic [3:0]  ROW_COUNT     = 4'h4;
  localparam logic [3:0]  COL_COUNT     = 4'h3;
  localparam logic [1:0]  SCAN_SETTLE   = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SCAN = 2'b01,
    ST_WAIT = 2'b11
  } scan_state_type;

  // cross-point address to ascii, zero when the address has no key
  function automatic logic [7:0] xpoint_to_char(input logic [7:0] xp);
    logic [7:0] ch;
    ch = CHAR_NONE;
    unique case (xp)
      8'hc1:   ch = 8'h37;
      8'hc2:   ch = 8'h38;
      8'hc0:   ch = 8'h39;
      8'hc9:   ch = 8'h34;
      8'hca:   ch = 8'h35;
      8'hcb:   ch = 8'h36;
      8'hd1:   ch = 8'h31;
      8'hd2:   ch = 8'h32;
      8'hd0:   ch = 8'h33;
      8'hda:   ch = 8'h30;
      8'hd9:   ch = 8'h2d;
      8'hdb:   ch = 8'h2e;
      8'he1:   ch = 8'h41;
      8'he2:   ch = 8'h42;
      8'he0:   ch = 8'h43;
      8'he9:   ch = 8'h44;
      8'hea:   ch = 8'h45;
      8'heb:   ch = 8'h46;
      8'hf1:   ch = 8'h53;
      8'hf2:   ch = 8'h52;
      8'hf0:   ch = 8'h49;
      8'hfa:   ch = 8'h4b;
      8'hfb:   ch = 8'h4c;
      default: ch = CHAR_NONE;
    endcase
    return ch;
  endfunction
endpackage

// ---- verif/keypad_queue_sva.sv ----
// port assertions for the keypad command queue
`timescale 1ns/1ps
module keypad_queue_sva #(
  parameter int DEPTH = 64,
  parameter int WIDTH = 8
) (
  input wire logic             clock_in,
  input wire logic             sys_rst_in,
  input wire logic [3:0]       row_drive_unused_in,
  input wire logic [2:0]       col_sense_in,
  input wire logic [3:0]       row_drive_out,
  input wire logic             key_event_out,
  input wire logic             key_dropped_out,
  input wire logic [WIDTH-1:0] rd_data_out,
  input wire logic             rd_valid_out,
  input wire logic             rd_ready_in,
  input wire logic             empty_out,
  input wire logic             full_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  ev_pulse_a: assert property (key_event_out |=> !key_event_out)
    else $error("key event longer than one cycle");
  scan_row_a: assert property (key_event_out |-> $onehot(row_drive_out))
    else $error("no single row driven at scan start");
  ascii_only_a: assert property (rd_valid_out |-> rd_data_out != '0)
    else $error("untranslated byte offered");
  empty_valid_a: assert property (empty_out |-> !rd_valid_out)
    else $error("byte offered while empty");
  data_hold_a: assert property (rd_valid_out && !rd_ready_in |=> rd_valid_out && $stable(rd_data_out))
    else $error("offered byte changed before taken");
  full_empty_a: assert property (!(full_out && empty_out))
    else $error("full and empty together");
  full_hold_a: assert property (full_out && !rd_ready_in |=> full_out)
    else $error("full cleared without a read");
  drop_full_a: assert property (key_dropped_out |-> $past(full_out) && !key_event_out)
    else $error("key dropped while room left");
  cover property (key_event_out);
  cover property (key_dropped_out);
  cover property (rd_valid_out && rd_ready_in);
endmodule
bind keypad_ascii_command_queue keypad_queue_sva #(.DEPTH(DEPTH), .WIDTH(WIDTH)) chk (.*);

// ---- verif/keypad_matrix_model.sv ----
// keypad cross-point matrix stand-in
`timescale 1ns/1ps
module keypad_matrix_model (
  input  wire logic [3:0] row_drive_in,
  input  wire logic       press_in,
  input  wire logic [1:0] row_sel_in,
  input  wire logic [1:0] col_sel_in,
  output logic      [2:0] col_sense_out
);
  // a column reads high only while its row is driven
  assign col_sense_out = (press_in && row_drive_in[row_sel_in]) ? 3'h1 << col_sel_in : 3'h0;
endmodule

// ---- verif/keypad_ascii_command_queue_bench.sv ----
// bench for the keypad command queue
`timescale 1ns/1ps
module keypad_ascii_command_queue_bench;
  import keypad_queue_pkg::*;
  logic        clock_in = 0;
  logic        sys_rst_in = 1;
  logic        rd_ready_in = 0;
  logic        press = 0;
  logic [3:0]  row_drive_unused_in = 0;
  logic [1:0]  row_sel = 0;
  logic [1:0]  col_sel = 0;
  logic [2:0]  col_sense_in;
  logic [3:0]  row_drive_out;
  logic [7:0]  rd_data_out;
  logic        key_event_out, key_dropped_out, rd_valid_out, empty_out, full_out;
  int          err_total = 0;
  int          compares = 0;
  logic [15:0] keys [23] = '{16'hc137, 16'hc238, 16'hc039, 16'hc934, 16'hca35, 16'hcb36,
    16'hd131, 16'hd232, 16'hd033, 16'hda30, 16'hd92d, 16'hdb2e, 16'he141, 16'he242,
    16'he043, 16'he944, 16'hea45, 16'heb46, 16'hf153, 16'hf252, 16'hf049, 16'hfa4b, 16'hfb4c};

  keypad_ascii_command_queue uut (.*);
  keypad_matrix_model pad (.row_drive_in(row_drive_out), .press_in(press), .row_sel_in(row_sel),
    .col_sel_in(col_sel), .col_sense_out(col_sense_in));

  always #5 clock_in = ~clock_in;

  task automatic check(input string what, input logic [7:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // consumer side: digits, minus and point go to number handling, the rest are commands
  function automatic logic is_numeric(input logic [7:0] b);
    return (b >= 8'h30 && b <= 8'h39) || b == 8'h2d || b == 8'h2e;
  endfunction

  task automatic close_out();
    if (err_total == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // key held well past the scan, then released so the scanner rearms
  task automatic press_key(input logic [7:0] xp, output logic ev, dr);
    ev = 0;
    dr = 0;
    row_drive_unused_in = {4{xp[3]}};
    row_sel = xp[5:4];
    col_sel = (xp[1:0] == 2'h0) ? 2'h2 : xp[1:0] - 2'h1;
    press = 1;
    repeat (30) begin
      @(posedge clock_in) #1;
      ev |= key_event_out;
      dr |= key_dropped_out;
    end
    press = 0;
    repeat (8) @(posedge clock_in);
    #1;
  endtask

  task automatic pop(output logic [7:0] d);
    int i;
    i = 0;
    do begin
      @(posedge clock_in) #1;
      i++;
    end while (rd_valid_out !== 1'b1 && i < 50);
    if (rd_valid_out !== 1'b1) begin
      err_total++;
      close_out();
    end else begin
      d = rd_data_out;
      rd_ready_in = 1;
      @(posedge clock_in) #1;
      rd_ready_in = 0;
    end
  endtask

  task automatic all_keys();
    logic       ev, dr;
    logic [7:0] d;
    foreach (keys[k]) begin
      press_key(keys[k][15:8], ev, dr);
      check("key_event", ev, 8'h1);
      check("dropped", dr, 8'h0);
      pop(d);
      check("ascii", d, keys[k][7:0]);
      check("numeric", 8'(is_numeric(d)), 8'(k < 12));
    end
    // a cross-point with no key assigned must yield no byte
    press_key(8'hf9, ev, dr);
    check("key_event", ev, 8'h1);
    check("no_key", rd_valid_out, 8'h0);
    check("empty", empty_out, 8'h1);
  endtask

  // consumer stalls during the fill so the tail presses must be refused
  task automatic fill_drain();
    logic       ev, dr;
    logic [7:0] d;
    int         kept;
    kept = 0;
    for (int n = 0; n < 80; n++) begin
      press_key(keys[n % 23][15:8], ev, dr);
      if (dr !== 1'b1) kept++;
    end
    check("full", full_out, 8'h1);
    check("kept", 8'(kept), 8'h40);
    for (int n = 0; n < kept; n++) begin
      pop(d);
      check("order", d, keys[n % 23][7:0]);
    end
    check("empty", empty_out, 8'h1);
  endtask

  initial begin
    repeat (4) @(posedge clock_in);
    #1 sys_rst_in = 0;
    check("rows_idle", {4'h0, row_drive_out}, 8'h0f);
    all_keys();
    fill_drain();
    close_out();
  end
endmodule
